// File: ldd_decode_top.sv
// Logical device I/O decode and interrupt level select, registers reached over APB.
// Assumes LPC address, requests and mode inputs come from logic clocked by pclk.
//
// The implementer's own choice: the APB interface to the registers.
`include "ldd_cfg.svh"
module ldd_decode_top
  import ldd_pkg::*;
#(
  parameter int LPC_AW = 16
)
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // LPC I/O cycle.
  input  wire logic [15:0] lpc_io_addr,
  input  wire logic        lpc_io_cyc,
  // Device selects.
  output logic             rtc0_addr_sel,
  output logic             rtc0_data_sel,
  output logic             rtc1_addr_sel,
  output logic             rtc1_data_sel,
  output logic             keyboard_host_port_data_sel,
  output logic             keyboard_host_port_cmd_sel,
  output logic             embedded_ctrl_interface_data_sel,
  output logic             embedded_ctrl_interface_cmd_sel,
  // Interrupt sources and routing.
  input  wire logic [3:0]  dev_irq_req,
  input  wire logic        pp_ext_mode,
  output logic [15:0]      serirq_slot,
  output logic [15:0]      irq_pin,
  // Parallel port shadow.
  output logic [7:0]       parallel_config_b
);
  // Elaboration check: the decode is built for a 16-bit LPC I/O space.
  if (LPC_AW != 16) begin : g_bad_aw
    $error("LPC_AW must be 16");
  end

  localparam logic [3:0] LDN [4] = '{`LDD_LDN_RTC, `LDD_LDN_KBD, `LDD_LDN_EMB, `LDD_LDN_PP};

  // Registers.
  ldd_io_addr_type rtc0_base_r, rtc1_base_r, emb_base_r;
  ldd_level_type   irq_sel_r [4];
  logic [7:0]      cfgb_r;
  logic            pready_r, pslverr_r;
  logic [31:0]     prdata_r;
  logic [7:0]      sel_r;
  logic [15:0]     slot_r, pin_r;

  // APB address split: logical device number and register index.
  wire       [3:0] ldn      = paddr[13:10];
  wire       [7:0] idx      = paddr[9:2];
  wire             adr_ok   = (paddr[31:14] == 18'h00000) && (paddr[1:0] == 2'h0);
  wire             is_rtc   = adr_ok && (ldn == `LDD_LDN_RTC);
  wire             is_emb   = adr_ok && (ldn == `LDD_LDN_EMB);
  wire             is_pp    = adr_ok && (ldn == `LDD_LDN_PP);
  wire             b0_hi    = (is_rtc || is_emb) && (idx == `LDD_IDX_BASE0_HI);
  wire             b0_lo    = (is_rtc || is_emb) && (idx == `LDD_IDX_BASE0_LO);
  wire             b1_hi    = is_rtc && (idx == `LDD_IDX_BASE1_HI);
  wire             b1_lo    = is_rtc && (idx == `LDD_IDX_BASE1_LO);
  wire             cfgb_hit = is_pp && (idx == `LDD_IDX_PP_CFGB);
  logic      [3:0] irq_hit;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_irq_hit
    assign irq_hit[g] = adr_ok && (ldn == LDN[g]) && (idx == `LDD_IDX_IRQ_SEL);
  end
  wire             map_hit  = b0_hi | b0_lo | b1_hi | b1_lo | cfgb_hit | (|irq_hit);

  // Access handshake: one wait state, then the transfer completes.
  wire             acc      = psel && penable && !pready_r;
  wire             done     = psel && penable && pready_r;
  wire             wr_go    = done && pwrite && map_hit;

  // Read data selection; the level field sits in bits 3-0 and bits 7-4 read zero.
  ldd_io_addr_type b0_val;
  assign b0_val = is_emb ? emb_base_r : rtc0_base_r;
  wire       [3:0] irq_rd   = irq_hit[0] ? irq_sel_r[0] :
                              irq_hit[1] ? irq_sel_r[1] :
                              irq_hit[2] ? irq_sel_r[2] :
                              irq_hit[3] ? irq_sel_r[3] : 4'h0;
  wire       [7:0] rd_byte  = b0_hi      ? b0_val[15:8] :
                              b0_lo      ? b0_val[7:0] :
                              b1_hi      ? rtc1_base_r[15:8] :
                              b1_lo      ? rtc1_base_r[7:0] :
                              cfgb_hit   ? cfgb_r :
                              {4'h0, irq_rd};
  wire      [31:0] rd_nxt   = {24'h000000, rd_byte};

  // APB answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc && !map_hit;
      if (acc) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
      end
    end
  end

  // Base address registers, written one byte at a time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc0_base_r <= `LDD_RST_BASE;
      rtc1_base_r <= `LDD_RST_BASE;
      emb_base_r  <= `LDD_RST_BASE;
    end else if (wr_go) begin
      if (b0_hi && is_rtc) rtc0_base_r[15:8] <= pwdata[7:0];
      if (b0_lo && is_rtc) rtc0_base_r[7:0]  <= pwdata[7:0];
      if (b0_hi && is_emb) emb_base_r[15:8]  <= pwdata[7:0];
      if (b0_lo && is_emb) emb_base_r[7:0]   <= pwdata[7:0];
      if (b1_hi)           rtc1_base_r[15:8] <= pwdata[7:0];
      if (b1_lo)           rtc1_base_r[7:0]  <= pwdata[7:0];
    end
  end

  // Level select per device; only bits 3-0 are stored.
  for (g = 0; g < 4; g++) begin : g_irq_sel
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_sel_r[g] <= `LDD_RST_IRQ_SEL;
      end else if (wr_go && irq_hit[g]) begin
        irq_sel_r[g] <= pwdata[3:0];
      end
    end
  end

  // Parallel port shadow: changed only by its own index, never by a level write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfgb_r <= `LDD_RST_CFGB;
    end else if (wr_go && cfgb_hit) begin
      cfgb_r <= pwdata[7:0];
    end
  end

  // I/O windows: rtc0 addr, rtc0 data, rtc1 addr, rtc1 data, controller data, controller cmd.
  ldd_io_addr_type w_base [6];
  ldd_io_addr_type w_lo   [6];
  ldd_io_addr_type w_hi   [6];
  ldd_io_addr_type w_ofs  [6];
  logic      [5:0] w_hit;
  assign w_base = '{rtc0_base_r, rtc0_base_r, rtc1_base_r, rtc1_base_r, emb_base_r, emb_base_r};
  assign w_lo   = '{`LDD_RTC0_LO, `LDD_RTC0_LO, `LDD_RTC1_LO, `LDD_RTC1_LO,
                    `LDD_EMB_LO, `LDD_EMB_LO};
  assign w_hi   = '{`LDD_RTC0_HI, `LDD_RTC0_HI, `LDD_RTC1_HI, `LDD_RTC1_HI,
                    `LDD_EMB_HI, `LDD_EMB_HI};
  assign w_ofs  = '{`LDD_OFS_ADDR, `LDD_OFS_RTC0_DAT, `LDD_OFS_ADDR, `LDD_OFS_RTC1_DAT,
                    `LDD_OFS_ADDR, `LDD_OFS_EMB_CMD};
  for (g = 0; g < 6; g++) begin : g_win
    ldd_io_match u_match (
      .addr (lpc_io_addr),
      .cyc  (lpc_io_cyc),
      .base (w_base[g]),
      .lo   (w_lo[g]),
      .hi   (w_hi[g]),
      .ofs  (w_ofs[g]),
      .hit  (w_hit[g])
    );
  end

  // Fixed keyboard ports, compared on all sixteen bits.
  wire kbd_dat = lpc_io_cyc && (lpc_io_addr == `LDD_KBD_DATA);
  wire kbd_cmd = lpc_io_cyc && (lpc_io_addr == `LDD_KBD_CMD);
  wire [7:0] sel_nxt = {kbd_cmd, kbd_dat, w_hit};

  // Interrupt routing; the parallel port drives its pin line low-active while in extended modes.
  logic          req_a [4];
  logic          low_a [4];
  logic [15:0]   slot_nxt, pin_nxt;
  for (g = 0; g < 4; g++) begin : g_src
    assign req_a[g] = dev_irq_req[g];
    assign low_a[g] = (g == int'(LDD_SRC_PP)) ? pp_ext_mode : 1'b0;
  end
  ldd_irq_route #(.NUM_SRC(4)) u_route (
    .req     (req_a),
    .sel     (irq_sel_r),
    .act_low (low_a),
    .slot    (slot_nxt),
    .pin     (pin_nxt)
  );

  // Output flops for selects and interrupt lines.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r  <= 8'h00;
      slot_r <= 16'h0000;
      pin_r  <= 16'h0000;
    end else begin
      sel_r  <= sel_nxt;
      slot_r <= slot_nxt;
      pin_r  <= pin_nxt;
    end
  end

  assign prdata                           = prdata_r;
  assign pready                           = pready_r;
  assign pslverr                          = pslverr_r;
  assign rtc0_addr_sel                    = sel_r[0];
  assign rtc0_data_sel                    = sel_r[1];
  assign rtc1_addr_sel                    = sel_r[2];
  assign rtc1_data_sel                    = sel_r[3];
  assign embedded_ctrl_interface_data_sel = sel_r[4];
  assign embedded_ctrl_interface_cmd_sel  = sel_r[5];
  assign keyboard_host_port_data_sel      = sel_r[6];
  assign keyboard_host_port_cmd_sel       = sel_r[7];
  assign serirq_slot                      = slot_r;
  assign irq_pin                          = pin_r;
  assign parallel_config_b                = cfgb_r;

  // Checks of decode, level select and routing.
  AST_KBD_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && lpc_io_addr == 16'h0060) |=> keyboard_host_port_data_sel
      && !keyboard_host_port_cmd_sel)
    else $error("Keyboard data port not selected at 0x60.");
  AST_KBD_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    keyboard_host_port_cmd_sel |-> $past(lpc_io_cyc) && $past(lpc_io_addr) == 16'h0064)
    else $error("Keyboard command select without access to 0x64.");
  AST_RTC0_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && rtc0_base_r >= 16'h0100 && rtc0_base_r <= 16'h0FFE
      && lpc_io_addr == rtc0_base_r + 16'h0001) |=> rtc0_data_sel && !rtc0_addr_sel)
    else $error("RTC bank 0 data register not decoded at base+1.");
  AST_RTC1_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    rtc1_data_sel |-> $past(rtc1_base_r) <= 16'h0FFD && $past(rtc1_base_r) >= 16'h0100
      && $past(lpc_io_addr) == $past(rtc1_base_r) + 16'h0002)
    else $error("RTC bank 1 data select outside its window.");
  AST_EMB_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && emb_base_r <= 16'h0FFA && lpc_io_addr == emb_base_r + 16'h0004)
      |=> embedded_ctrl_interface_cmd_sel)
    else $error("Embedded controller command not decoded at base+4.");
  AST_FULL_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && lpc_io_addr[15:12] != 4'h0 && lpc_io_addr != 16'h0060
      && lpc_io_addr != 16'h0064) |=> sel_r == 8'h00)
    else $error("Select raised for an address with high bits set.");
  AST_IRQ_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && irq_hit[3]) ##1 pready_r |-> prdata_r == {28'h0000000, irq_sel_r[3]})
    else $error("Level select readback wrong or upper bits not zero.");
  AST_NO_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_sel_r[0] == 4'h0 && irq_sel_r[1] == 4'h0 && irq_sel_r[2] == 4'h0
      && irq_sel_r[3] == 4'h0) [*2] |-> slot_r == 16'h0000 && pin_r == 16'h0000)
    else $error("Interrupt routed while every level is zero.");
  AST_LEVEL_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    (dev_irq_req[0] && irq_sel_r[0] != 4'h0) |=> serirq_slot[$past(irq_sel_r[0])]
      && irq_pin[$past(irq_sel_r[0])])
    else $error("RTC request missing on its slot or pin.");
  AST_PP_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (pp_ext_mode && !dev_irq_req[3] && irq_sel_r[3] != 4'h0) |=> irq_pin[$past(irq_sel_r[3])])
    else $error("Parallel port extended mode pin not low-active.");
  AST_CFGB_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && irq_hit[3]) |=> $stable(parallel_config_b))
    else $error("Level write changed the parallel shadow.");

  // Handshake, window and routing checks that complete the rule coverage.
  AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("Access phase not answered after one wait state.");
  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");
  AST_SLVERR_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("Error response without ready.");
  AST_LEVEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && irq_hit[0]) |=> {28'h0000000, irq_sel_r[0]} == ($past(pwdata) & 32'h0000000F))
    else $error("Level write not stored in bits 3-0 only.");
  AST_RTC0_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && rtc0_base_r >= 16'h0100 && rtc0_base_r <= 16'h0FFE
      && lpc_io_addr == rtc0_base_r) |=> rtc0_addr_sel)
    else $error("RTC bank 0 address register not decoded at base+0.");
  AST_RTC0_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    rtc0_addr_sel |-> $past(rtc0_base_r) >= 16'h0100 && $past(rtc0_base_r) <= 16'h0FFE)
    else $error("RTC bank 0 address select with base out of range.");
  AST_RTC1_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && rtc1_base_r >= 16'h0100 && rtc1_base_r <= 16'h0FFD
      && lpc_io_addr == rtc1_base_r) |=> rtc1_addr_sel)
    else $error("RTC bank 1 address register not decoded at base+0.");
  AST_EMB_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    (lpc_io_cyc && emb_base_r <= 16'h0FFA && lpc_io_addr == emb_base_r)
      |=> embedded_ctrl_interface_data_sel)
    else $error("Embedded controller data not decoded at base+0.");
  AST_SEL_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !lpc_io_cyc |=> sel_r == 8'h00)
    else $error("Select raised without an I/O cycle.");
  AST_LEVEL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_sel_r[0] == 4'h0 && dev_irq_req == 4'h1) |=> serirq_slot == 16'h0000)
    else $error("Level zero routed a request onto a slot.");
  AST_LINE0_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !serirq_slot[0] && !irq_pin[0])
    else $error("Line 0 driven.");
  AST_PIN_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (!pp_ext_mode && dev_irq_req == 4'h0) |=> irq_pin == 16'h0000)
    else $error("Pin line high with no request pending.");
endmodule // ldd_decode_top

// File: ldd_cfg.svh
// Constants of the logical device decode and interrupt select block.
// Assumes it is included by every design file and by the bench; the package does not include it.
`ifndef LDD_CFG_SVH
`define LDD_CFG_SVH
`define LDD_LDN_PP       4'h3
`define LDD_LDN_RTC      4'h6
`define LDD_LDN_KBD      4'h7
`define LDD_LDN_EMB      4'h8
`define LDD_IDX_BASE0_HI 8'h60
`define LDD_IDX_BASE0_LO 8'h61
`define LDD_IDX_BASE1_HI 8'h62
`define LDD_IDX_BASE1_LO 8'h63
`define LDD_IDX_IRQ_SEL  8'h70
`define LDD_IDX_PP_CFGB  8'hF1
`define LDD_RTC0_LO      16'h0100
`define LDD_RTC0_HI      16'h0FFE
`define LDD_RTC1_LO      16'h0100
`define LDD_RTC1_HI      16'h0FFD
`define LDD_EMB_LO       16'h0000
`define LDD_EMB_HI       16'h0FFA
`define LDD_OFS_ADDR     16'h0000
`define LDD_OFS_RTC0_DAT 16'h0001
`define LDD_OFS_RTC1_DAT 16'h0002
`define LDD_OFS_EMB_CMD  16'h0004
`define LDD_KBD_DATA     16'h0060
`define LDD_KBD_CMD      16'h0064
`define LDD_RST_BASE     16'h0000
`define LDD_RST_IRQ_SEL  4'h0
`define LDD_RST_CFGB     8'h00
`endif

// File: ldd_pkg.sv
// Types shared by the logical device decode and interrupt select block.
// Assumes nothing of its surroundings.
package ldd_pkg;
  typedef logic [3:0]  ldd_level_type;
  typedef logic [15:0] ldd_io_addr_type;
  // Slots of the interrupt sources, in router input order.
  typedef enum logic [1:0] {
    LDD_SRC_RTC = 2'h0,
    LDD_SRC_KBD = 2'h1,
    LDD_SRC_EMB = 2'h2,
    LDD_SRC_PP  = 2'h3
  } ldd_src_type;
endpackage : ldd_pkg

// File: ldd_io_match.sv
// One relocatable I/O window: full-width compare of an LPC address with base plus offset.
// Assumes the base is a register of the same clock and the address is already synchronous.
`include "ldd_cfg.svh"
module ldd_io_match
  import ldd_pkg::*;
(
  // LPC side.
  input  wire ldd_io_addr_type addr,
  input  wire logic            cyc,
  // Window setup.
  input  wire ldd_io_addr_type base,
  input  wire ldd_io_addr_type lo,
  input  wire ldd_io_addr_type hi,
  input  wire ldd_io_addr_type ofs,
  // Result.
  output wire logic            hit
);
  // A base outside its legal range disables the window entirely.
  wire             base_ok = (base >= lo) && (base <= hi);
  wire ldd_io_addr_type tgt = ldd_io_addr_type'(base + ofs);
  assign hit = cyc && base_ok && (addr == tgt);
endmodule // ldd_io_match

// File: ldd_irq_route.sv
// Routes interrupt requests onto numbered lines for serial IRQ slots and pins.
// Assumes requests and selects are synchronous to the caller's clock.
`include "ldd_cfg.svh"
module ldd_irq_route
  import ldd_pkg::*;
#(
  parameter int NUM_SRC = 4
)
(
  // Sources.
  input  wire logic          req     [NUM_SRC],
  input  wire ldd_level_type sel     [NUM_SRC],
  input  wire logic          act_low [NUM_SRC],
  // Lines 0 to 15, line 0 never driven.
  output logic [15:0]        slot,
  output logic [15:0]        pin
);
  // Each line from 1 to 15 collects every source whose level equals its number.
  genvar l;
  for (l = 0; l < 16; l++) begin : g_line
    always_comb begin
      slot[l] = 1'b0;
      pin[l]  = 1'b0;
      for (int s = 0; s < NUM_SRC; s++) begin
        if ((l != 0) && (sel[s] == ldd_level_type'(l))) begin
          slot[l] = slot[l] | req[s];
          pin[l]  = pin[l] | (act_low[s] ? ~req[s] : req[s]);
        end
      end
    end
  end
endmodule // ldd_irq_route

// File: ldd_lpc_host.sv
// Behavioural LPC host that issues single I/O cycles to the decode block.
// Assumes the bench calls io_cycle from one process that is synchronous to pclk.
module ldd_lpc_host (
  // Clock.
  input  wire logic   pclk,
  // LPC I/O cycle.
  output logic [15:0] lpc_io_addr,
  output logic        lpc_io_cyc
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus starts idle with a pattern that matches no window.
  initial begin
    lpc_io_addr = 16'hFFFF;
    lpc_io_cyc  = 1'b0;
  end

  // Drives one qualified address for a single cycle, then shows its inverse so stale
  // addresses never look valid.
  task automatic io_cycle(input logic [15:0] a);
    @(posedge pclk);
    lpc_io_addr <= a;
    lpc_io_cyc  <= 1'b1;
    @(posedge pclk);
    lpc_io_addr <= ~a;
    lpc_io_cyc  <= 1'b0;
  endtask
endmodule // ldd_lpc_host

// File: testbench.sv
// Self-checking bench for the logical device decode and interrupt select block.
// Assumes the design files and ldd_lpc_host are compiled before this file.
`include "ldd_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lpc_io_cyc, pp_ext_mode;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] lpc_io_addr, serirq_slot, irq_pin;
  logic [7:0]  sels, parallel_config_b;
  logic [3:0]  dev_irq_req;
  int          num_errors, cmp_count;

  // Design and far-side host.
  ldd_decode_top i_ldd_decode_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lpc_io_addr(lpc_io_addr), .lpc_io_cyc(lpc_io_cyc),
    .rtc0_addr_sel(sels[7]), .rtc0_data_sel(sels[6]), .rtc1_addr_sel(sels[5]),
    .rtc1_data_sel(sels[4]), .keyboard_host_port_data_sel(sels[3]),
    .keyboard_host_port_cmd_sel(sels[2]), .embedded_ctrl_interface_data_sel(sels[1]),
    .embedded_ctrl_interface_cmd_sel(sels[0]), .dev_irq_req(dev_irq_req),
    .pp_ext_mode(pp_ext_mode), .serirq_slot(serirq_slot), .irq_pin(irq_pin),
    .parallel_config_b(parallel_config_b));
  ldd_lpc_host i_ldd_lpc_host (.pclk(pclk), .lpc_io_addr(lpc_io_addr), .lpc_io_cyc(lpc_io_cyc));

  // Clock of 4 ns period.
  always #2 pclk = ~pclk;

  // Compares one value and counts the result.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [3:0] ldn, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {18'h0, ldn, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look just after each edge; a high pready there is sampled at the next edge.
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("MISMATCH at %0t: no pready within 20 cycles", $time);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write without checks.
  task automatic wr(input logic [3:0] ldn, input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ldn, idx, d, r, e);
  endtask

  // Register read compared with an expected word.
  task automatic rd_chk(input logic [3:0] ldn, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ldn, idx, 32'h0, r, e);
    check(r, exp, "read data");
    check({31'h0, e}, 32'h0, "read error");
  endtask

  // One LPC I/O cycle and the select pattern that must follow it.
  task automatic lpc_chk(input logic [15:0] a, input logic [7:0] exp);
    i_ldd_lpc_host.io_cycle(a);
    #1;
    check({24'h0, sels}, {24'h0, exp}, "select pattern");
  endtask

  // Applies requests and checks slot and pin lines one cycle later.
  task automatic irq_chk(input logic [3:0] req, input logic ext, input logic [15:0] es,
                         input logic [15:0] ep);
    @(posedge pclk);
    dev_irq_req <= req;
    pp_ext_mode <= ext;
    @(posedge pclk);
    #1;
    check({16'h0, serirq_slot}, {16'h0, es}, "serial slot");
    check({16'h0, irq_pin}, {16'h0, ep}, "pin lines");
  endtask

  // Level registers: reset value, upper nibble dropped, unmapped index refused.
  task automatic test_regs();
    logic [3:0]  ldns [4] = '{`LDD_LDN_PP, `LDD_LDN_RTC, `LDD_LDN_KBD, `LDD_LDN_EMB};
    logic [31:0] r;
    logic        e;
    foreach (ldns[i]) begin
      rd_chk(ldns[i], `LDD_IDX_IRQ_SEL, 32'h0);
      wr(ldns[i], `LDD_IDX_IRQ_SEL, 32'hFF);
      rd_chk(ldns[i], `LDD_IDX_IRQ_SEL, 32'h0F);
    end
    apb(1'b1, `LDD_LDN_KBD, `LDD_IDX_BASE0_HI, 32'h12, r, e);
    check({31'h0, e}, 32'h1, "unmapped write error");
    $display("test_regs done");
  endtask

  // Fixed and relocatable windows, full-width compare and range limits.
  task automatic test_decode();
    lpc_chk(16'h0060, 8'h08);
    lpc_chk(16'h0064, 8'h04);
    lpc_chk(16'h0061, 8'h00);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE0_HI, 32'h03);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE0_LO, 32'h70);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE1_HI, 32'h0F);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE1_LO, 32'hFD);
    wr(`LDD_LDN_EMB, `LDD_IDX_BASE0_HI, 32'h0F);
    wr(`LDD_LDN_EMB, `LDD_IDX_BASE0_LO, 32'hFA);
    lpc_chk(16'h0370, 8'h80);
    lpc_chk(16'h0371, 8'h40);
    lpc_chk(16'h8370, 8'h00);
    lpc_chk(16'h0FFD, 8'h20);
    lpc_chk(16'h0FFF, 8'h10);
    lpc_chk(16'h0FFA, 8'h02);
    lpc_chk(16'h0FFE, 8'h01);
    lpc_chk(16'h0FFB, 8'h00);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE0_LO, 32'hFF);
    lpc_chk(16'h03FF, 8'h80);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE0_HI, 32'h0F);
    lpc_chk(16'h0FFF, 8'h10);
    wr(`LDD_LDN_RTC, `LDD_IDX_BASE0_HI, 32'h00);
    lpc_chk(16'h00FF, 8'h00);
    $display("test_decode done");
  endtask

  // Every level value, every source, and the parallel port polarity.
  task automatic test_irq();
    logic [3:0] ldns [4] = '{`LDD_LDN_RTC, `LDD_LDN_KBD, `LDD_LDN_EMB, `LDD_LDN_PP};
    for (int l = 0; l < 16; l++) begin
      wr(`LDD_LDN_RTC, `LDD_IDX_IRQ_SEL, 32'(l));
      irq_chk(4'h1, 1'b0, (l == 0) ? 16'h0 : 16'(1 << l), (l == 0) ? 16'h0 : 16'(1 << l));
    end
    for (int s = 0; s < 4; s++) begin
      wr(ldns[s], `LDD_IDX_IRQ_SEL, 32'(s + 9));
      irq_chk(4'(1 << s), 1'b0, 16'(1 << (s + 9)), 16'(1 << (s + 9)));
    end
    irq_chk(4'h0, 1'b0, 16'h0, 16'h0);
    irq_chk(4'h0, 1'b1, 16'h0, 16'h1000);
    irq_chk(4'h8, 1'b1, 16'h1000, 16'h0);
    $display("test_irq done");
  endtask

  // Parallel port level writes leave the shadow alone; the shadow is written on its own.
  task automatic test_shadow();
    wr(`LDD_LDN_PP, `LDD_IDX_IRQ_SEL, 32'h09);
    rd_chk(`LDD_LDN_PP, `LDD_IDX_PP_CFGB, 32'h0);
    check({24'h0, parallel_config_b}, 32'h0, "shadow after level write");
    wr(`LDD_LDN_PP, `LDD_IDX_PP_CFGB, 32'hA5);
    rd_chk(`LDD_LDN_PP, `LDD_IDX_PP_CFGB, 32'hA5);
    check({24'h0, parallel_config_b}, 32'hA5, "shadow output");
    rd_chk(`LDD_LDN_PP, `LDD_IDX_IRQ_SEL, 32'h09);
    $display("test_shadow done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset for eight cycles, then every scenario.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dev_irq_req = 4'h0;
    pp_ext_mode = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_decode();
    test_irq();
    test_shadow();
    results();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #20000;
    num_errors++;
    results();
  end
endmodule // testbench
